// File: core/uef_defs.svh
/*
 * Constants of the USB error flag block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

// Bus geometry
`define UEF_DW           32
`define UEF_AW           4
`define UEF_HSIZE_WORD   3'h2
`define UEF_WORD_ZERO    32'h0000_0000

// Register byte offsets
`define UEF_OFS_FLAGS    4'h0
`define UEF_OFS_MASK     4'h4
`define UEF_OFS_CTRL     4'h8
`define UEF_OFS_STAT     4'hC

// Flag layout
`define UEF_FLAG_W       8
`define UEF_FLAG_RST     8'h00
`define UEF_BIT_PID      0
`define UEF_BIT_TOK      1
`define UEF_BIT_BTO      4
`define UEF_BIT_DMA      5

// Control and state fields
`define UEF_CTRL_HOST    0
`define UEF_STAT_HOST    0
`define UEF_STAT_BUSY    1
`define UEF_STAT_TURN    2
`define UEF_STAT_GWAIT   3
`define UEF_STAT_RXPKT   4

// Timing: clock period, bit time and turnaround window
`define UEF_CLK_PS       4000
`define UEF_BIT_TIME_PS  83333
`define UEF_TURN_BITS    16
`define UEF_TURN_CYC     ((`UEF_TURN_BITS * `UEF_BIT_TIME_PS + `UEF_CLK_PS - 1) / `UEF_CLK_PS)
`define UEF_TURN_CNT_W   9

// Memory grant wait and receive buffer check
`define UEF_GNT_WAIT     16
`define UEF_GNT_CNT_W    8
`define UEF_BUF_LEN_W    10
`define UEF_RX_CNT_W     11

`endif

// File: core/uef_pkg.sv
/*
 * Types of the USB error flag block: state encodings and the packed
 * state records of each module.
 * Assumes uef_defs.svh is on the include path.
 */
`include "uef_defs.svh"

package uef_pkg;

   typedef enum logic [1:0] {
      UEF_TT_IDLE = 2'b01,
      UEF_TT_WAIT = 2'b10
   } uef_tt_state_t;

   typedef struct packed {
      logic flag;
   } uef_flag_regs_t;

   typedef struct packed {
      uef_tt_state_t               state;
      logic [`UEF_TURN_CNT_W-1:0]  cnt;
      logic                        timeout;
   } uef_tt_regs_t;

   typedef struct packed {
      logic                        rst_meta;
      logic                        rst_sync;
   } uef_rst_regs_t;

   typedef struct packed {
      logic                        wr_pend;
      logic                        rd_pend;
      logic                        rd_wait;
      logic [`UEF_AW-1:0]          addr;
      logic [`UEF_DW-1:0]          rdata;
      logic [`UEF_FLAG_W-1:0]      mask;
      logic                        host_mode;
      logic [`UEF_GNT_CNT_W-1:0]   gnt_cnt;
      logic                        gnt_late;
      logic                        rx_in_pkt;
      logic [`UEF_RX_CNT_W-1:0]    rx_cnt;
      logic                        rx_trunc;
      logic                        irq;
   } uef_regs_t;

endpackage : uef_pkg

// File: core/uef_flag_bit.sv
/*
 * One sticky error flag: set by hardware, cleared by a software
 * write of one.
 * Assumes a reset already synchronised to clk.
 */
`timescale 1ns/1ps

module uef_flag_bit (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   uef_pkg::uef_flag_regs_t r_q;
   uef_pkg::uef_flag_regs_t r_d;

   always_comb begin
      r_d = r_q;
      if (set) begin
         r_d.flag = 1'b1;
      end else if (clr) begin
         r_d.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.flag;

endmodule : uef_flag_bit

// File: core/uef_turn_timer.sv
/*
 * Bus turnaround watchdog: after an end-of-packet that expects an
 * answer, counts idle cycles and pulses timeout past the window.
 * Assumes a reset already synchronised to clk; inputs synchronous.
 */
`timescale 1ns/1ps
`include "uef_defs.svh"

module uef_turn_timer #(
   parameter int TURN_CYC = `UEF_TURN_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic eop_done,
   input  wire logic resp_expected,
   input  wire logic bus_idle,
   input  wire logic resp_start,
   output logic      active,
   output logic      timeout
);

   localparam logic [`UEF_TURN_CNT_W-1:0] LIMIT = TURN_CYC[`UEF_TURN_CNT_W-1:0];

   if (TURN_CYC < 1 || TURN_CYC >= (1 << `UEF_TURN_CNT_W)) begin : g_bad_turn_cyc
      $error("uef_turn_timer: TURN_CYC out of range");
   end

   uef_pkg::uef_tt_regs_t r_q;
   uef_pkg::uef_tt_regs_t r_d;

   always_comb begin
      r_d         = r_q;
      r_d.timeout = 1'b0;
      case (r_q.state)
         uef_pkg::UEF_TT_IDLE: begin
            if (eop_done && resp_expected) begin
               r_d.state = uef_pkg::UEF_TT_WAIT;
               r_d.cnt   = '0;
            end
         end
         uef_pkg::UEF_TT_WAIT: begin
            if (resp_start) begin
               r_d.state = uef_pkg::UEF_TT_IDLE;
            end else if (bus_idle) begin
               r_d.cnt = r_q.cnt + 1'b1;
               if (r_d.cnt == LIMIT) begin
                  r_d.timeout = 1'b1;
                  r_d.state   = uef_pkg::UEF_TT_IDLE;
               end
            end
         end
         default: begin
            r_d.state = uef_pkg::UEF_TT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q.state   <= uef_pkg::UEF_TT_IDLE;
         r_q.cnt     <= '0;
         r_q.timeout <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign active  = (r_q.state == uef_pkg::UEF_TT_WAIT);
   assign timeout = r_q.timeout;

endmodule : uef_turn_timer

// File: core/uef_error_flags.sv
/*
 * USB error flag block: lower error flags of the error status register,
 * their event detection, an interrupt mask and an AHB-Lite slave.
 * Assumes a single slave on the bus (hreadyout is hready) and event
 * inputs from the USB engine that are synchronous to sys_clk.
 * Register map, one word each, low eight bits used:
 *    0x0 error flags, write one to clear
 *    0x4 interrupt mask, same layout as the flags
 *    0x8 control, bit 0 selects host mode
 *    0xC state, read only: host, link busy, turnaround armed,
 *        grant wait, inside a received packet
 * Reads take one wait state, writes none; the response is always OKAY.
 * Unmapped offsets read zero and drop writes; other sizes are ignored.
 * The turnaround window is in sys_clk cycles, rounded up from bit times.
 * Flags set by hardware win over a clear written in the same cycle.
 */
// The register addresses and the AHB-Lite register port were left to the implementer.
// Summary of operation
// - Device mode: token dropped for bad 5-bit checksum sets bit 1.
// - Host mode: bit 1 instead reports an end-of-frame error.
// - End-of-frame error when busy on the link as frame countdown hits zero.
// - Received PID failing its check field sets bit 0.
// - Memory bus grant arriving too late sets the memory transfer flag.
// - Received packet longer than its buffer sets the memory transfer flag.
// - Over sixteen idle bit times after end-of-packet sets turnaround flag.
// - Flags set by hardware, cleared by writing one, reset to zero.
`timescale 1ns/1ps
`include "uef_defs.svh"

module uef_error_flags #(
   parameter int GNT_WAIT = `UEF_GNT_WAIT,
   parameter int TURN_CYC = `UEF_TURN_CYC
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // AHB-Lite slave and interrupt output
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [`UEF_DW-1:0]        hwdata,
   input  wire logic                      hready,
   output logic      [`UEF_DW-1:0]        hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic                           irq,
   // Token and PID checks
   input  wire logic                      token_done,
   input  wire logic                      token_crc_ok,
   input  wire logic                      pid_valid,
   input  wire logic [3:0]                pid_code,
   input  wire logic [3:0]                pid_check,
   // Frame timing
   input  wire logic                      sof_count_zero,
   input  wire logic                      tx_active,
   input  wire logic                      rx_active,
   // Memory transfer
   input  wire logic                      mem_req,
   input  wire logic                      mem_gnt,
   input  wire logic                      rx_pkt_start,
   input  wire logic                      rx_byte,
   input  wire logic                      rx_pkt_end,
   input  wire logic [`UEF_BUF_LEN_W-1:0] buf_len,
   // Bus turnaround
   input  wire logic                      eop_done,
   input  wire logic                      resp_expected,
   input  wire logic                      bus_idle,
   input  wire logic                      resp_start
);

   localparam logic [`UEF_GNT_CNT_W-1:0] GNT_LIMIT = GNT_WAIT[`UEF_GNT_CNT_W-1:0];

   if (GNT_WAIT < 1 || GNT_WAIT >= (1 << `UEF_GNT_CNT_W)) begin : g_bad_gnt_wait
      $error("uef_error_flags: GNT_WAIT out of range");
   end

   if (TURN_CYC < 1 || TURN_CYC >= (1 << `UEF_TURN_CNT_W)) begin : g_bad_turn_cyc
      $error("uef_error_flags: TURN_CYC out of range");
   end

   if (`UEF_RX_CNT_W != `UEF_BUF_LEN_W + 1) begin : g_bad_rx_cnt_w
      $error("uef_error_flags: receive count must be one bit wider than buf_len");
   end

   // Reset release through two flops
   // Entry stays asynchronous; only the release is retimed
   uef_pkg::uef_rst_regs_t rs_q;
   logic                   rst_int_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rs_q <= '0;
      end else begin
         rs_q.rst_meta <= 1'b1;
         rs_q.rst_sync <= rs_q.rst_meta;
      end
   end

   assign rst_int_n = rs_q.rst_sync;

   // Block state other than the flag bits, turnaround timer and reset flops in one record
   uef_pkg::uef_regs_t r_q;
   uef_pkg::uef_regs_t r_d;

   logic [`UEF_FLAG_W-1:0] flags;
   logic [`UEF_FLAG_W-1:0] flag_set;
   logic [`UEF_FLAG_W-1:0] flag_clr;
   logic                   turn_active;
   logic                   turn_timeout;
   logic                   addr_take;
   logic                   link_busy;
   logic                   tok_bad;
   logic                   eof_err;
   logic                   pid_bad;
   logic                   gnt_evt;
   logic                   trunc_evt;
   logic [`UEF_DW-1:0]     rd_word;

   // Address phase of a word transfer to this slave
   assign addr_take = hsel && hready && htrans[1] && (hsize == `UEF_HSIZE_WORD);
   assign link_busy = tx_active || rx_active;

   // Event detection
   // Bit 1 is shared: checksum in device mode, end of frame in host mode
   assign tok_bad = !r_q.host_mode && token_done && !token_crc_ok;
   assign eof_err = r_q.host_mode && sof_count_zero && link_busy;
   assign pid_bad = pid_valid && (pid_check != ~pid_code);

   // Grant late: once per request, as the wait reaches the limit
   // Counter saturates, so a long stall cannot wrap and fire again
   assign gnt_evt = mem_req && !mem_gnt && !r_q.gnt_late
                    && ((r_q.gnt_cnt + 1'b1) == GNT_LIMIT);

   // Byte arriving once the buffer is already full
   // Bytes past the buffer are not counted; one flag per packet
   assign trunc_evt = r_q.rx_in_pkt && rx_byte && !r_q.rx_trunc
                      && (r_q.rx_cnt >= {1'b0, buf_len});

   // Hardware set requests, one per flag position
   always_comb begin
      flag_set = `UEF_FLAG_RST;
      flag_set[`UEF_BIT_PID] = pid_bad;
      flag_set[`UEF_BIT_TOK] = tok_bad || eof_err;
      flag_set[`UEF_BIT_BTO] = turn_timeout;
      flag_set[`UEF_BIT_DMA] = gnt_evt || trunc_evt;
   end

   // Write-one-to-clear in the data phase of a status write
   always_comb begin
      flag_clr = `UEF_FLAG_RST;
      if (r_q.wr_pend && (r_q.addr == `UEF_OFS_FLAGS)) begin
         flag_clr = hwdata[`UEF_FLAG_W-1:0];
      end
   end

   // One sticky bit per implemented flag position
   uef_flag_bit u_flag_pid (
      .clk   (sys_clk),
      .rst_n (rst_int_n),
      .set   (flag_set[`UEF_BIT_PID]),
      .clr   (flag_clr[`UEF_BIT_PID]),
      .q     (flags[`UEF_BIT_PID])
   );

   uef_flag_bit u_flag_tok (
      .clk   (sys_clk),
      .rst_n (rst_int_n),
      .set   (flag_set[`UEF_BIT_TOK]),
      .clr   (flag_clr[`UEF_BIT_TOK]),
      .q     (flags[`UEF_BIT_TOK])
   );

   uef_flag_bit u_flag_bto (
      .clk   (sys_clk),
      .rst_n (rst_int_n),
      .set   (flag_set[`UEF_BIT_BTO]),
      .clr   (flag_clr[`UEF_BIT_BTO]),
      .q     (flags[`UEF_BIT_BTO])
   );

   uef_flag_bit u_flag_dma (
      .clk   (sys_clk),
      .rst_n (rst_int_n),
      .set   (flag_set[`UEF_BIT_DMA]),
      .clr   (flag_clr[`UEF_BIT_DMA]),
      .q     (flags[`UEF_BIT_DMA])
   );

   // Unimplemented flag positions read as zero
   assign flags[3:2] = 2'h0;
   assign flags[7:6] = 2'h0;

   // Turnaround watchdog; its one-cycle timeout pulse sets bit 4
   uef_turn_timer #(
      .TURN_CYC (TURN_CYC)
   ) u_turn (
      .clk           (sys_clk),
      .rst_n         (rst_int_n),
      .eop_done      (eop_done),
      .resp_expected (resp_expected),
      .bus_idle      (bus_idle),
      .resp_start    (resp_start),
      .active        (turn_active),
      .timeout       (turn_timeout)
   );

   // Read mux, sampled in the wait cycle after pending writes land
   // Busy and grant-wait state bits show live inputs, not latched copies
   always_comb begin
      rd_word = `UEF_WORD_ZERO;
      if (r_q.addr == `UEF_OFS_FLAGS) begin
         rd_word[`UEF_FLAG_W-1:0] = flags;
      end else if (r_q.addr == `UEF_OFS_MASK) begin
         rd_word[`UEF_FLAG_W-1:0] = r_q.mask;
      end else if (r_q.addr == `UEF_OFS_CTRL) begin
         rd_word[`UEF_CTRL_HOST] = r_q.host_mode;
      end else if (r_q.addr == `UEF_OFS_STAT) begin
         rd_word[`UEF_STAT_HOST]  = r_q.host_mode;
         rd_word[`UEF_STAT_BUSY]  = link_busy;
         rd_word[`UEF_STAT_TURN]  = turn_active;
         rd_word[`UEF_STAT_GWAIT] = mem_req && !mem_gnt;
         rd_word[`UEF_STAT_RXPKT] = r_q.rx_in_pkt;
      end
   end

   always_comb begin
      r_d = r_q;

      // Bus side
      // Write data lands one cycle after its address phase
      r_d.wr_pend = 1'b0;
      r_d.rd_wait = 1'b0;
      if (r_q.rd_pend) begin
         r_d.rd_pend = 1'b0;
         r_d.rd_wait = 1'b1;
         r_d.rdata   = rd_word;
      end
      if (r_q.wr_pend) begin
         if (r_q.addr == `UEF_OFS_MASK) begin
            r_d.mask = hwdata[`UEF_FLAG_W-1:0];
         end else if (r_q.addr == `UEF_OFS_CTRL) begin
            r_d.host_mode = hwdata[`UEF_CTRL_HOST];
         end
      end
      if (addr_take && !r_q.rd_pend) begin
         r_d.addr    = haddr[`UEF_AW-1:0];
         r_d.wr_pend = hwrite;
         r_d.rd_pend = !hwrite;
      end

      // Memory grant wait counter
      if (mem_req && !mem_gnt) begin
         if (r_q.gnt_cnt != GNT_LIMIT) begin
            r_d.gnt_cnt = r_q.gnt_cnt + 1'b1;
         end
         if (gnt_evt) begin
            r_d.gnt_late = 1'b1;
         end
      end else begin
         r_d.gnt_cnt  = '0;
         r_d.gnt_late = 1'b0;
      end

      // Received byte count against the buffer size
      if (rx_pkt_start) begin
         r_d.rx_in_pkt = 1'b1;
         r_d.rx_cnt    = '0;
         r_d.rx_trunc  = 1'b0;
      end else if (r_q.rx_in_pkt) begin
         if (rx_byte && !trunc_evt && !r_q.rx_trunc) begin
            r_d.rx_cnt = r_q.rx_cnt + 1'b1;
         end
         if (trunc_evt) begin
            r_d.rx_trunc = 1'b1;
         end
         if (rx_pkt_end) begin
            r_d.rx_in_pkt = 1'b0;
         end
      end

      // Registered level, one cycle behind the flags
      r_d.irq = |(flags & r_q.mask);
   end

   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // Refused transfers are ignored, never answered with an error
   assign hrdata    = r_q.rdata;
   assign hreadyout = !r_q.rd_pend;
   assign hresp     = 1'b0;
   assign irq       = r_q.irq;

endmodule : uef_error_flags

// File: tb/uef_error_flags_props.sv
/* Checker of the USB error flag block, watching the top module's ports.
   Assumes the mask and host-mode writes can be followed from the bus. */
`timescale 1ns/1ps
`include "uef_defs.svh"

module uef_error_flags_props #(
   parameter int GNT_WAIT = 16,
   parameter int TURN_CYC = 334
) (
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [2:0]          hsize,
   input wire logic [`UEF_DW-1:0]  hwdata,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic                irq,
   input wire logic                token_done,
   input wire logic                token_crc_ok,
   input wire logic                pid_valid,
   input wire logic [3:0]          pid_code,
   input wire logic [3:0]          pid_check,
   input wire logic                sof_count_zero,
   input wire logic                tx_active,
   input wire logic                rx_active,
   input wire logic                mem_req,
   input wire logic                mem_gnt,
   input wire logic                eop_done,
   input wire logic                resp_expected,
   input wire logic                bus_idle,
   input wire logic                resp_start
);
   logic [7:0] msk;
   logic [7:0] gw;
   logic [8:0] tc;
   logic [3:0] wa;
   logic       hst;
   logic       wp;
   logic       arm;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Shadow of mask, host mode, grant wait and idle count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         msk <= 8'h00;
         gw  <= 8'h00;
         tc  <= 9'h000;
         wa  <= 4'h0;
         hst <= 1'b0;
         wp  <= 1'b0;
         arm <= 1'b0;
      end else begin
         if (hready) begin
            wp <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            wa <= haddr[3:0];
         end
         if (wp && hready && wa == 4'h4) msk <= hwdata[7:0];
         if (wp && hready && wa == 4'h8) hst <= hwdata[0];
         gw <= (mem_req && !mem_gnt) ? gw + 8'h01 : 8'h00;
         if (eop_done && resp_expected) begin
            arm <= 1'b1;
            tc  <= 9'h000;
         end else if (resp_start) arm <= 1'b0;
         else if (arm && bus_idle) tc <= tc + 9'h001;
      end
   end

   chk_token_err: assert property (
      !hst && token_done && !token_crc_ok && msk[1] |-> ##2 irq) else $error("token error missed");
   chk_frame_end: assert property (
      hst && sof_count_zero && (tx_active || rx_active) && msk[1] |-> ##2 irq)
      else $error("frame end error missed");
   chk_pid_err: assert property (
      pid_valid && pid_check != ~pid_code && msk[0] |-> ##2 irq) else $error("pid error missed");
   chk_grant_late: assert property (
      mem_req && !mem_gnt && gw == GNT_WAIT - 1 && msk[5] |-> ##2 irq)
      else $error("late grant missed");
   chk_turn_timeout: assert property (
      arm && bus_idle && tc == TURN_CYC - 1 && msk[4] |-> ##[1:4] irq)
      else $error("turnaround timeout missed");
   chk_irq_quiet: assert property ($past(msk) == 8'h00 |-> !irq) else $error("irq while masked");
   chk_read_wait: assert property (
      hsel && hready && htrans[1] && !hwrite && hsize == 3'h2 |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_okay_resp: assert property (!hresp) else $error("response not okay");
endmodule : uef_error_flags_props

bind uef_error_flags uef_error_flags_props #(.GNT_WAIT(GNT_WAIT), .TURN_CYC(TURN_CYC))
   i_uef_error_flags_props (.*);

// File: tb/uef_usb_model.sv
/* USB engine stand-in: drives the event inputs of the error flag block.
   Assumes its tasks are called just after a rising edge of sys_clk. */
`timescale 1ns/1ps

module uef_usb_model (
   input  wire logic sys_clk,
   output logic       token_done     = 1'b0,
   output logic       token_crc_ok   = 1'b1,
   output logic       pid_valid      = 1'b0,
   output logic [3:0] pid_code       = 4'h0,
   output logic [3:0] pid_check      = 4'hF,
   output logic       sof_count_zero = 1'b0,
   output logic       tx_active      = 1'b0,
   output logic       rx_active      = 1'b0,
   output logic       mem_req        = 1'b0,
   output logic       mem_gnt        = 1'b0,
   output logic       rx_pkt_start   = 1'b0,
   output logic       rx_byte        = 1'b0,
   output logic       rx_pkt_end     = 1'b0,
   output logic       eop_done       = 1'b0,
   output logic       resp_expected  = 1'b0,
   output logic       bus_idle       = 1'b0,
   output logic       resp_start     = 1'b0
);
   task automatic tok(input logic ok);
      token_done   <= 1'b1;
      token_crc_ok <= ok;
      @(posedge sys_clk);
      token_done <= 1'b0;
      @(posedge sys_clk);
   endtask : tok
   task automatic pid(input logic [3:0] c, input logic [3:0] k);
      pid_valid <= 1'b1;
      pid_code  <= c;
      pid_check <= k;
      @(posedge sys_clk);
      pid_valid <= 1'b0;
      @(posedge sys_clk);
   endtask : pid
   task automatic sof(input logic t, input logic x);
      sof_count_zero <= 1'b1;
      tx_active      <= t;
      rx_active      <= x;
      @(posedge sys_clk);
      sof_count_zero <= 1'b0;
      tx_active      <= 1'b0;
      rx_active      <= 1'b0;
      @(posedge sys_clk);
   endtask : sof
   // Request held n cycles before the grant comes
   task automatic grant(input int n);
      mem_req <= 1'b1;
      repeat (n) @(posedge sys_clk);
      mem_gnt <= 1'b1;
      @(posedge sys_clk);
      mem_req <= 1'b0;
      mem_gnt <= 1'b0;
      @(posedge sys_clk);
   endtask : grant
   task automatic rx(input int n);
      rx_pkt_start <= 1'b1;
      @(posedge sys_clk);
      rx_pkt_start <= 1'b0;
      rx_byte      <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rx_byte    <= 1'b0;
      rx_pkt_end <= 1'b1;
      @(posedge sys_clk);
      rx_pkt_end <= 1'b0;
      @(posedge sys_clk);
   endtask : rx
   // Idle bus for n cycles, then answer or stay silent
   task automatic turn(input int n, input logic ans);
      eop_done      <= 1'b1;
      resp_expected <= 1'b1;
      @(posedge sys_clk);
      eop_done      <= 1'b0;
      resp_expected <= 1'b0;
      bus_idle      <= 1'b1;
      repeat (n) @(posedge sys_clk);
      bus_idle   <= 1'b0;
      resp_start <= ans;
      @(posedge sys_clk);
      resp_start <= 1'b0;
      @(posedge sys_clk);
   endtask : turn
endmodule : uef_usb_model

// File: tb/tb_uef_error_flags.sv
/* Self-checking bench of the USB error flag block.
   Assumes the USB engine model and the bound checker are compiled first. */
`timescale 1ns/1ps

module tb_uef_error_flags;
   localparam int GW = 4;
   localparam int TC = 8;
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [9:0]  buf_len = 10'h004;
   logic [31:0] hrdata, r;
   logic        hready, hreadyout, hresp, irq, token_done, token_crc_ok, pid_valid;
   logic        sof_count_zero, tx_active, rx_active, mem_req, mem_gnt, rx_pkt_start;
   logic        rx_byte, rx_pkt_end, eop_done, resp_expected, bus_idle, resp_start;
   logic [3:0]  pid_code, pid_check;
   int          n_errors = 0;
   int          checks   = 0;

   assign hready = hreadyout;
   uef_error_flags #(.GNT_WAIT(GW), .TURN_CYC(TC)) i_uef_error_flags (.*);
   uef_usb_model i_uef_usb_model (.*);

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One single word transfer; r holds the read data
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      logic rdy;
      haddr  <= a;
      hwrite <= w;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      do begin
         @(negedge sys_clk);
         rdy = hready;
         @(posedge sys_clk);
      end while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge sys_clk);
         rdy = hready;
         r   = hrdata;
         @(posedge sys_clk);
      end while (rdy !== 1'b1);
   endtask : bus
   // Read the flags, then clear the expected ones
   task automatic flags(input logic [31:0] e);
      bus(1'b0, 32'h0, 32'h0);
      chk("flags", r, e);
      if (e != 32'h0) bus(1'b1, 32'h0, e);
   endtask : flags
   task automatic irq_is(input logic e);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
      @(posedge sys_clk);
   endtask : irq_is
   task automatic conclude();
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic t_reset();
      flags(32'h0);
      irq_is(1'b0);
      bus(1'b1, 32'h4, 32'hFF);
      bus(1'b0, 32'h4, 32'h0);
      chk("mask", r, 32'hFF);
   endtask : t_reset
   task automatic t_token();
      i_uef_usb_model.tok(1'b1);
      flags(32'h0);
      i_uef_usb_model.tok(1'b0);
      bus(1'b1, 32'h0, 32'h0);
      flags(32'h2);
      flags(32'h0);
      i_uef_usb_model.sof(1'b1, 1'b0);
      flags(32'h0);
   endtask : t_token
   task automatic t_host();
      bus(1'b1, 32'h8, 32'h1);
      bus(1'b0, 32'h8, 32'h0);
      chk("control", r, 32'h1);
      bus(1'b0, 32'hC, 32'h0);
      chk("state", r, 32'h1);
      i_uef_usb_model.tok(1'b0);
      flags(32'h0);
      i_uef_usb_model.sof(1'b0, 1'b0);
      flags(32'h0);
      i_uef_usb_model.sof(1'b1, 1'b0);
      flags(32'h2);
      i_uef_usb_model.sof(1'b0, 1'b1);
      flags(32'h2);
      bus(1'b1, 32'h8, 32'h0);
   endtask : t_host
   task automatic t_pid();
      for (logic [4:0] c = 5'h00; c < 5'h10; c++) i_uef_usb_model.pid(c[3:0], ~c[3:0]);
      flags(32'h0);
      i_uef_usb_model.pid(4'h5, 4'h5);
      flags(32'h1);
   endtask : t_pid
   task automatic t_mem();
      i_uef_usb_model.grant(GW - 1);
      flags(32'h0);
      i_uef_usb_model.grant(GW);
      flags(32'h20);
      i_uef_usb_model.rx(4);
      flags(32'h0);
      i_uef_usb_model.rx(5);
      flags(32'h20);
   endtask : t_mem
   task automatic t_turn();
      i_uef_usb_model.turn(TC - 2, 1'b1);
      flags(32'h0);
      i_uef_usb_model.turn(TC + 2, 1'b0);
      flags(32'h10);
   endtask : t_turn
   // Clear write lands on the same edge as a new error
   task automatic t_race();
      i_uef_usb_model.pid(4'h3, 4'h3);
      fork
         bus(1'b1, 32'h0, 32'h1);
         begin
            @(posedge sys_clk);
            i_uef_usb_model.pid(4'h3, 4'h3);
         end
      join
      flags(32'h1);
   endtask : t_race
   task automatic t_irq();
      i_uef_usb_model.pid(4'h3, 4'h3);
      irq_is(1'b1);
      bus(1'b1, 32'h4, 32'h0);
      irq_is(1'b0);
      bus(1'b1, 32'h4, 32'h1);
      irq_is(1'b1);
      flags(32'h1);
      irq_is(1'b0);
   endtask : t_irq

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_token();
      t_host();
      t_pid();
      t_mem();
      t_turn();
      t_race();
      t_irq();
      conclude();
   end

   initial begin
      #100000;
      n_errors++;
      conclude();
   end
endmodule : tb_uef_error_flags
